// ==== ladder_contact_compare_unit_tb_top.sv ====
// Self-checking testbench of the ladder contact compare unit.
`timescale 1ns/10ps
module ladder_contact_compare_unit_tb_top;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic sv, dw, pf, ct, dn, bad, pf_exp;
   logic [8:0] code;
   lcc_pkg::lcc_src_type s1, s2;
   logic [15:0] r1l, r1h, r2l, r2h;
   logic [31:0] c1, k1, c2, k2;
   int err_count = 0;
   int num_checks = 0;
   logic [31:0] va [6] = '{32'hc8, 32'hffffffe2, 32'h5, 32'ha5a5d, 32'h10000, 32'hf};
   logic [31:0] vb [6] = '{32'hc8, 32'h5, 32'hffffffe2, 32'h186a0, 32'h20000, 32'hf0};

   always #20 clock = ~clock;

   lcc_scan_seq_model i_seq (.step_valid(sv), .step_code(code), .double_word(dw),
      .first_source_sel(s1), .first_reg_lo(r1l), .first_reg_hi(r1h), .first_cnt_value(c1),
      .first_const_value(k1), .second_source_sel(s2), .second_reg_lo(r2l),
      .second_reg_hi(r2h), .second_cnt_value(c2), .second_const_value(k2));

   lcc_contact_unit i_dut (.clock(clock), .rst_n(rst_n), .step_valid(sv), .step_code(code),
      .double_word(dw), .first_source_sel(s1), .first_reg_lo(r1l), .first_reg_hi(r1h),
      .first_cnt_value(c1), .first_const_value(k1), .second_source_sel(s2),
      .second_reg_lo(r2l), .second_reg_hi(r2h), .second_cnt_value(c2),
      .second_const_value(k2), .power_flow_r(pf), .contact_r(ct), .step_done_r(dn),
      .bad_code_r(bad));

   // ----------------------------------------------------------------------
   // Reference and checks
   // ----------------------------------------------------------------------
   // Returns {refused, contact, next power flow}.
   function automatic logic [2:0] model(input int c, input logic d, input logic [31:0] x,
                                        input logic [31:0] y, input logic p);
      logic [31:0] a;
      logic [31:0] b;
      logic [31:0] r;
      logic        hit;
      int          fam;
      int          off;
      a = d ? x : {{16{x[15]}}, x[15:0]};
      b = d ? y : {{16{y[15]}}, y[15:0]};
      off = (c - 224) % 8;
      if (c >= 215 && c <= 223) begin
         fam = (c - 215) / 3;
         r = ((c - 215) % 3 == 0) ? a & b : ((c - 215) % 3 == 1) ? a | b : a ^ b;
         hit = d ? (r != 0) : (r[15:0] != 0);
      end else if (c >= 224 && c <= 246 && off != 3 && off != 7) begin
         fam = (c - 224) / 8;
         case (off)
            0: hit = $signed(a) == $signed(b);
            1: hit = $signed(a) > $signed(b);
            2: hit = $signed(a) < $signed(b);
            4: hit = $signed(a) != $signed(b);
            5: hit = $signed(a) <= $signed(b);
            default: hit = $signed(a) >= $signed(b);
         endcase
      end else begin
         return {1'b1, 1'b0, p};
      end
      return {1'b0, hit, (fam == 0) ? hit : (fam == 1) ? (p & hit) : (p | hit)};
   endfunction

   task automatic chk(input logic got, input logic exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask

   task automatic end_sim();
      if (err_count == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   // Every code of the range with each operand pair in both widths, back to back.
   task automatic all_codes();
      logic [2:0] e;
      for (int k = 0; k < 6; k++) begin
         for (int d = 0; d < 2; d++) begin
            for (int c = 215; c <= 246; c++) begin
               e = model(c, d[0], va[k], vb[k], pf_exp);
               i_seq.issue(c[8:0], d[0], lcc_pkg::lcc_src_type'(k % 3), va[k],
                           lcc_pkg::lcc_src_type'((k + 1) % 3), vb[k]);
               @(posedge clock);
               #1;
               chk(dn, 1'b1, "step not done");
               chk(bad, e[2], "refusal flag wrong");
               chk(ct, e[1], "contact result wrong");
               chk(pf, e[0], "power flow wrong");
               pf_exp = e[0];
            end
         end
      end
   endtask

   // Selector code 3 is not a listed source; it must read the register pair.
   task automatic odd_source();
      logic [2:0] e;
      e = model(224, 1'b1, 32'h12345678, 32'h12345678, pf_exp);
      i_seq.issue(9'h0e0, 1'b1, lcc_pkg::lcc_src_type'(2'h3), 32'h12345678,
                  lcc_pkg::SRC_CONST, 32'h12345678);
      @(posedge clock);
      #1;
      chk(ct, e[1], "source code 3 not read as register");
      chk(pf, e[0], "power flow wrong after odd source");
      pf_exp = e[0];
   endtask

   task automatic no_step();
      i_seq.idle();
      @(posedge clock);
      #1;
      chk(dn, 1'b0, "done without step");
      chk(ct, 1'b0, "contact without step");
      chk(pf, pf_exp, "power flow not held");
   endtask

   task automatic mid_reset();
      rst_n = 1'b0;
      #1;
      chk(pf | ct | dn | bad, 1'b0, "outputs not cleared by reset");
      repeat (2) @(posedge clock);
      #1;
      rst_n = 1'b1;
      pf_exp = 1'b0;
      @(posedge clock);
      #1;
      chk(pf | ct | dn | bad, 1'b0, "outputs not clear after reset");
   endtask

   initial begin
      pf_exp = 1'b0;
      repeat (6) @(posedge clock);
      #1;
      rst_n = 1'b1;
      all_codes();
      odd_source();
      no_step();
      mid_reset();
      all_codes();
      no_step();
      end_sim();
   end

   initial begin
      #100us;
      err_count++;
      $display("MISMATCH %0t run did not finish", $time);
      end_sim();
   end
endmodule

// ==== lcc_contact_unit.sv ====
// Contact evaluation datapath for ladder bitwise-test and relational compare steps.
`timescale 1ns/10ps

// How it works
// - Bitwise-test family combines operands with AND, OR or XOR per its code.
// - Bitwise-test contact is on when the combined result is non-zero.
// - Load bitwise-test replaces the rung power flow with its own result.
// - Series bitwise-test ANDs its result into the preceding power flow.
// - Parallel bitwise-test ORs its result into the preceding power flow.
// - Every contact has a word form and a register-pair double-word form.
// - Load compare starts a rung from the busbar, replacing power flow.
// - Compare supports equal, greater, less, unequal, at-most and at-least.
// - Series compare ANDs its result into the preceding power flow.
// - Parallel compare ORs its result into the preceding power flow.
// - Relational compares treat both operands as signed values.
// - Operands come from registers, counter values or embedded constants.
module lcc_contact_unit (
   input  wire logic                                 clock,
   input  wire logic                                 rst_n,
   input  wire logic                                 step_valid,
   input  wire logic [lcc_pkg::CODE_W-1:0]           step_code,
   input  wire logic                                 double_word,
   input  wire lcc_pkg::lcc_src_type                 first_source_sel,
   input  wire logic [lcc_pkg::WORD_W-1:0]           first_reg_lo,
   input  wire logic [lcc_pkg::WORD_W-1:0]           first_reg_hi,
   input  wire logic [lcc_pkg::DWORD_W-1:0]          first_cnt_value,
   input  wire logic [lcc_pkg::DWORD_W-1:0]          first_const_value,
   input  wire lcc_pkg::lcc_src_type                 second_source_sel,
   input  wire logic [lcc_pkg::WORD_W-1:0]           second_reg_lo,
   input  wire logic [lcc_pkg::WORD_W-1:0]           second_reg_hi,
   input  wire logic [lcc_pkg::DWORD_W-1:0]          second_cnt_value,
   input  wire logic [lcc_pkg::DWORD_W-1:0]          second_const_value,
   output logic                                      power_flow_r,
   output logic                                      contact_r,
   output logic                                      step_done_r,
   output logic                                      bad_code_r
);

   // ----------------------------------------------------------------------
   // Decoding functions
   // ----------------------------------------------------------------------
   function automatic logic in_family(input logic [lcc_pkg::CODE_W-1:0] code,
                                      input logic [lcc_pkg::CODE_W-1:0] base,
                                      input logic [lcc_pkg::SUB_W-1:0]  last);
      logic [lcc_pkg::CODE_W-1:0] offs;
      offs = code - base;
      in_family = (code >= base) && (offs <= {{(lcc_pkg::CODE_W-lcc_pkg::SUB_W){1'b0}}, last});
   endfunction

   function automatic lcc_pkg::lcc_decode_type decode_op(
      input logic [lcc_pkg::CODE_W-1:0] code);
      lcc_pkg::lcc_decode_type    d;
      logic [lcc_pkg::CODE_W-1:0] base;
      d.valid     = 1'b1;
      d.is_cmp    = 1'b0;
      d.join_mode = lcc_pkg::JOIN_LOAD;
      base        = lcc_pkg::BIT_LOAD_BASE;
      if (in_family(code, lcc_pkg::BIT_LOAD_BASE, lcc_pkg::BIT_LAST_SUB)) begin
         base = lcc_pkg::BIT_LOAD_BASE;
      end else if (in_family(code, lcc_pkg::BIT_SERIES_BASE, lcc_pkg::BIT_LAST_SUB)) begin
         base        = lcc_pkg::BIT_SERIES_BASE;
         d.join_mode = lcc_pkg::JOIN_SERIES;
      end else if (in_family(code, lcc_pkg::BIT_PAR_BASE, lcc_pkg::BIT_LAST_SUB)) begin
         base        = lcc_pkg::BIT_PAR_BASE;
         d.join_mode = lcc_pkg::JOIN_PARALLEL;
      end else if (in_family(code, lcc_pkg::CMP_LOAD_BASE, lcc_pkg::CMP_LAST_SUB)) begin
         base     = lcc_pkg::CMP_LOAD_BASE;
         d.is_cmp = 1'b1;
      end else if (in_family(code, lcc_pkg::CMP_SERIES_BASE, lcc_pkg::CMP_LAST_SUB)) begin
         base        = lcc_pkg::CMP_SERIES_BASE;
         d.is_cmp    = 1'b1;
         d.join_mode = lcc_pkg::JOIN_SERIES;
      end else if (in_family(code, lcc_pkg::CMP_PAR_BASE, lcc_pkg::CMP_LAST_SUB)) begin
         base        = lcc_pkg::CMP_PAR_BASE;
         d.is_cmp    = 1'b1;
         d.join_mode = lcc_pkg::JOIN_PARALLEL;
      end else begin
         d.valid = 1'b0;
      end
      d.sub = lcc_pkg::SUB_W'(code - base);
      // The gap code inside each compare family is refused.
      if (d.is_cmp && d.sub == lcc_pkg::REL_GAP) begin
         d.valid = 1'b0;
      end
      decode_op = d;
   endfunction

   // ----------------------------------------------------------------------
   // Operand fetch
   // ----------------------------------------------------------------------
   wire logic [lcc_pkg::DWORD_W-1:0] first_operand;
   wire logic [lcc_pkg::DWORD_W-1:0] second_operand;

   // Double-word forms take {hi, lo} pairs, word forms the low word.
   lcc_operand_select u_first_sel (
      .src         (first_source_sel),
      .double_word (double_word),
      .reg_lo      (first_reg_lo),
      .reg_hi      (first_reg_hi),
      .cnt_value   (first_cnt_value),
      .const_value (first_const_value),
      .operand     (first_operand)
   );

   lcc_operand_select u_second_sel (
      .src         (second_source_sel),
      .double_word (double_word),
      .reg_lo      (second_reg_lo),
      .reg_hi      (second_reg_hi),
      .cnt_value   (second_cnt_value),
      .const_value (second_const_value),
      .operand     (second_operand)
   );

   // ----------------------------------------------------------------------
   // Contact evaluation
   // ----------------------------------------------------------------------
   wire lcc_pkg::lcc_decode_type     dec;
   wire logic [lcc_pkg::DWORD_W-1:0] width_mask;
   wire logic [lcc_pkg::DWORD_W-1:0] bit_and;
   wire logic [lcc_pkg::DWORD_W-1:0] bit_or;
   wire logic [lcc_pkg::DWORD_W-1:0] bit_xor;
   wire logic [lcc_pkg::DWORD_W-1:0] bit_result;
   wire logic                        rel_eq;
   wire logic                        rel_lt;
   wire logic                        rel_hold;
   wire logic                        contact_nxt;
   wire logic                        power_flow_nxt;
   wire logic                        take_step;

   assign dec        = decode_op(step_code);
   assign take_step  = step_valid && dec.valid;

   // Word forms ignore the sign extension above bit 15.
   assign width_mask = double_word ? {lcc_pkg::DWORD_W{1'b1}}
                                   : {{lcc_pkg::WORD_W{1'b0}}, {lcc_pkg::WORD_W{1'b1}}};
   assign bit_and    = first_operand & second_operand & width_mask;
   assign bit_or     = (first_operand | second_operand) & width_mask;
   assign bit_xor    = (first_operand ^ second_operand) & width_mask;
   assign bit_result = (dec.sub == lcc_pkg::OP_AND) ? bit_and :
                       (dec.sub == lcc_pkg::OP_OR)  ? bit_or  : bit_xor;

   assign rel_eq     = (first_operand == second_operand);
   assign rel_lt     = ($signed(first_operand) < $signed(second_operand));
   // Each relation is on exactly when its complement is off.
   assign rel_hold   = (dec.sub == lcc_pkg::REL_EQ) ? rel_eq :
                       (dec.sub == lcc_pkg::REL_GT) ? !rel_lt && !rel_eq :
                       (dec.sub == lcc_pkg::REL_LT) ? rel_lt :
                       (dec.sub == lcc_pkg::REL_NE) ? !rel_eq :
                       (dec.sub == lcc_pkg::REL_LE) ? rel_lt || rel_eq :
                       !rel_lt;

   assign contact_nxt = dec.is_cmp ? rel_hold : (bit_result != '0);

   // Load replaces the power flow, series ANDs it, parallel ORs it.
   assign power_flow_nxt =
      (dec.join_mode == lcc_pkg::JOIN_SERIES)   ? power_flow_r && contact_nxt :
      (dec.join_mode == lcc_pkg::JOIN_PARALLEL) ? power_flow_r || contact_nxt :
      contact_nxt;

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   // A refused code leaves the rung power flow untouched and clears the contact.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         power_flow_r <= 1'b0;
         contact_r    <= 1'b0;
         step_done_r  <= 1'b0;
         bad_code_r   <= 1'b0;
      end else begin
         power_flow_r <= take_step ? power_flow_nxt : power_flow_r;
         contact_r    <= take_step && contact_nxt;
         step_done_r  <= step_valid;
         bad_code_r   <= step_valid && !dec.valid;
      end
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   wire logic load_bit    = take_step && !dec.is_cmp && dec.join_mode == lcc_pkg::JOIN_LOAD;
   wire logic load_cmp    = take_step && dec.is_cmp && dec.join_mode == lcc_pkg::JOIN_LOAD;
   wire logic series_step = take_step && dec.join_mode == lcc_pkg::JOIN_SERIES;
   wire logic par_step    = take_step && dec.join_mode == lcc_pkg::JOIN_PARALLEL;
   wire logic and_step    = take_step && !dec.is_cmp && dec.sub == lcc_pkg::OP_AND;
   wire logic lt_step     = take_step && dec.is_cmp && dec.sub == lcc_pkg::REL_LT;
   wire logic [lcc_pkg::DWORD_W-1:0] and_raw = first_operand & second_operand;
   wire logic signed [lcc_pkg::DWORD_W-1:0] first_s  = first_operand;
   wire logic signed [lcc_pkg::DWORD_W-1:0] second_s = second_operand;
   wire logic gap_code = step_valid && dec.is_cmp && dec.sub == lcc_pkg::REL_GAP;

   sequence s_step_then_done;
      step_valid ##1 step_done_r;
   endsequence

   a_bit_load_replace: assert property (
      load_bit |=> power_flow_r == contact_r)
      else $error("Load bitwise step did not replace power flow.");

   a_cmp_load_replace: assert property (
      load_cmp |=> power_flow_r == contact_r)
      else $error("Load compare step did not replace power flow.");

   a_series_joins_and: assert property (
      series_step |=> power_flow_r == ($past(power_flow_r) && contact_r))
      else $error("Series step did not AND into power flow.");

   a_parallel_joins_or: assert property (
      par_step |=> power_flow_r == ($past(power_flow_r) || contact_r))
      else $error("Parallel step did not OR into power flow.");

   a_and_test_nonzero: assert property (
      and_step && double_word |=> contact_r == ($past(and_raw) != '0))
      else $error("Bitwise AND test gave the wrong contact.");

   a_signed_less: assert property (
      lt_step |=> contact_r == ($past(first_s) < $past(second_s)))
      else $error("Signed less-than compare gave the wrong contact.");

   a_dword_pair: assert property (
      step_valid && double_word && first_source_sel == lcc_pkg::SRC_REG
      |-> first_operand == {first_reg_hi, first_reg_lo})
      else $error("Double-word operand is not the register pair.");

   a_gap_refused: assert property (
      gap_code |=> bad_code_r && !contact_r && power_flow_r == $past(power_flow_r))
      else $error("Gap code was taken as a contact.");

   a_step_done_once: assert property (
      s_step_then_done ##0 !step_valid |=> !step_done_r)
      else $error("Step done did not mark exactly one cycle.");

endmodule

// ==== lcc_operand_select.sv ====
// Operand selector: register pair, counter value or embedded constant.
`timescale 1ns/10ps
module lcc_operand_select (
   input  wire lcc_pkg::lcc_src_type          src,
   input  wire logic                          double_word,
   input  wire logic [lcc_pkg::WORD_W-1:0]    reg_lo,
   input  wire logic [lcc_pkg::WORD_W-1:0]    reg_hi,
   input  wire logic [lcc_pkg::DWORD_W-1:0]   cnt_value,
   input  wire logic [lcc_pkg::DWORD_W-1:0]   const_value,
   output wire logic [lcc_pkg::DWORD_W-1:0]   operand
);

   wire logic [lcc_pkg::DWORD_W-1:0] raw_value;
   wire logic [lcc_pkg::WORD_W-1:0]  low_word;

   // Unknown selector codes read as a register so the output is never open.
   assign raw_value = (src == lcc_pkg::SRC_CNT)   ? cnt_value   :
                      (src == lcc_pkg::SRC_CONST) ? const_value :
                      {reg_hi, reg_lo};
   assign low_word  = raw_value[lcc_pkg::WORD_W-1:0];

   // Word forms are sign extended so one signed comparator serves both widths.
   assign operand   = double_word ? raw_value
                                  : {{lcc_pkg::WORD_W{low_word[lcc_pkg::WORD_W-1]}}, low_word};

endmodule

// ==== lcc_pkg.sv ====
// Constants and types shared by the ladder contact compare unit.
package lcc_pkg;

   // ----------------------------------------------------------------------
   // Data widths
   // ----------------------------------------------------------------------
   localparam int WORD_W  = 16;
   localparam int DWORD_W = 32;
   localparam int CODE_W  = 9;
   localparam int SUB_W   = 3;

   // ----------------------------------------------------------------------
   // Instruction code families (first code of each family)
   // ----------------------------------------------------------------------
   localparam logic [CODE_W-1:0] BIT_LOAD_BASE   = 9'h0d7;
   localparam logic [CODE_W-1:0] BIT_SERIES_BASE = 9'h0da;
   localparam logic [CODE_W-1:0] BIT_PAR_BASE    = 9'h0dd;
   localparam logic [CODE_W-1:0] CMP_LOAD_BASE   = 9'h0e0;
   localparam logic [CODE_W-1:0] CMP_SERIES_BASE = 9'h0e8;
   localparam logic [CODE_W-1:0] CMP_PAR_BASE    = 9'h0f0;

   // Highest offset inside a family.
   localparam logic [SUB_W-1:0]  BIT_LAST_SUB    = 3'h2;
   localparam logic [SUB_W-1:0]  CMP_LAST_SUB    = 3'h6;

   // Offsets inside a bitwise-test family.
   localparam logic [SUB_W-1:0]  OP_AND          = 3'h0;
   localparam logic [SUB_W-1:0]  OP_OR           = 3'h1;
   localparam logic [SUB_W-1:0]  OP_XOR          = 3'h2;

   // Offsets inside a relational family; offset 3 is an unused gap.
   localparam logic [SUB_W-1:0]  REL_EQ          = 3'h0;
   localparam logic [SUB_W-1:0]  REL_GT          = 3'h1;
   localparam logic [SUB_W-1:0]  REL_LT          = 3'h2;
   localparam logic [SUB_W-1:0]  REL_GAP         = 3'h3;
   localparam logic [SUB_W-1:0]  REL_NE          = 3'h4;
   localparam logic [SUB_W-1:0]  REL_LE          = 3'h5;
   localparam logic [SUB_W-1:0]  REL_GE          = 3'h6;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      SRC_REG   = 2'h0,
      SRC_CNT   = 2'h1,
      SRC_CONST = 2'h2
   } lcc_src_type;

   typedef enum logic [2:0] {
      JOIN_LOAD     = 3'b001,
      JOIN_SERIES   = 3'b010,
      JOIN_PARALLEL = 3'b100
   } lcc_join_type;

   typedef struct packed {
      logic             valid;
      logic             is_cmp;
      lcc_join_type     join_mode;
      logic [SUB_W-1:0] sub;
   } lcc_decode_type;

endpackage

// ==== lcc_scan_seq_model.sv ====
// Scan sequencer model that presents instruction steps and operands to the contact unit.
`timescale 1ns/10ps
module lcc_scan_seq_model (
   output logic                        step_valid,
   output logic [lcc_pkg::CODE_W-1:0]  step_code,
   output logic                        double_word,
   output lcc_pkg::lcc_src_type        first_source_sel,
   output logic [lcc_pkg::WORD_W-1:0]  first_reg_lo,
   output logic [lcc_pkg::WORD_W-1:0]  first_reg_hi,
   output logic [lcc_pkg::DWORD_W-1:0] first_cnt_value,
   output logic [lcc_pkg::DWORD_W-1:0] first_const_value,
   output lcc_pkg::lcc_src_type        second_source_sel,
   output logic [lcc_pkg::WORD_W-1:0]  second_reg_lo,
   output logic [lcc_pkg::WORD_W-1:0]  second_reg_hi,
   output logic [lcc_pkg::DWORD_W-1:0] second_cnt_value,
   output logic [lcc_pkg::DWORD_W-1:0] second_const_value
);
   // ----------------------------------------------------------------------
   // Operand presentation
   // ----------------------------------------------------------------------
   // Sources that are not selected carry the inverse value, so a wrong pick is seen.
   initial begin
      step_valid = 1'b0;
      step_code = '0;
      double_word = 1'b0;
      first_source_sel = lcc_pkg::SRC_REG;
      second_source_sel = lcc_pkg::SRC_REG;
      {first_reg_lo, first_reg_hi, first_cnt_value, first_const_value} = '0;
      {second_reg_lo, second_reg_hi, second_cnt_value, second_const_value} = '0;
   end

   function automatic logic [95:0] place(input lcc_pkg::lcc_src_type s, input logic dw,
                                         input logic [31:0] v);
      logic [15:0] lo;
      logic [15:0] hi;
      lo = (s != lcc_pkg::SRC_CNT && s != lcc_pkg::SRC_CONST) ? v[15:0] : ~v[15:0];
      hi = (lo == v[15:0] && dw) ? v[31:16] : ~v[31:16];
      return {hi, lo, (s == lcc_pkg::SRC_CNT) ? v : ~v, (s == lcc_pkg::SRC_CONST) ? v : ~v};
   endfunction

   task automatic issue(input logic [8:0] code, input logic dw, input lcc_pkg::lcc_src_type s1,
                        input logic [31:0] v1, input lcc_pkg::lcc_src_type s2,
                        input logic [31:0] v2);
      step_valid = 1'b1;
      step_code = code;
      double_word = dw;
      first_source_sel = s1;
      second_source_sel = s2;
      {first_reg_hi, first_reg_lo, first_cnt_value, first_const_value} = place(s1, dw, v1);
      {second_reg_hi, second_reg_lo, second_cnt_value, second_const_value} = place(s2, dw, v2);
   endtask

   task automatic idle();
      step_valid = 1'b0;
      step_code = ~step_code;
   endtask
endmodule
